/* File: design/thermal_pkg.sv */
// Constants and types for the thermal pin and dynamic floor block
package thermal_pkg;
  localparam logic [7:0] OFS_FLOOR_A = 8'h0b;
  localparam logic [7:0] OFS_FLOOR_B = 8'h0c;
  localparam logic [7:0] OFS_PIN_COMMON = 8'h0d;
  localparam logic [7:0] OFS_PIN_A = 8'h0e;
  localparam logic [7:0] OFS_PIN_B = 8'h0f;
  localparam logic [7:0] RST_FLOOR_A = 8'h00;
  localparam logic [7:0] RST_FLOOR_B = 8'h40;
  localparam logic [7:0] RST_PIN_COMMON = 8'h00;
  localparam logic [4:0] RST_PIN_CFG = 5'h00;
  // Dynamic floor control a
  localparam int EN_R1 = 0;
  localparam int EN_R2 = 1;
  localparam int CAP_A_R1 = 2;
  localparam int CAP_A_R2 = 3;
  localparam int CAP_B_R1 = 4;
  localparam int CAP_B_R2 = 5;
  // Dynamic floor control b
  localparam int CYC_R1_LSB = 0;
  localparam int CYC_R2_LSB = 3;
  localparam int LOOP_SEL = 6;
  // Common pin config
  localparam int BOOST_A = 0;
  localparam int BOOST_B = 1;
  localparam int WIN_A_LSB = 2;
  localparam int WIN_B_LSB = 5;
  // Per-pin config
  localparam int TIMER_EN = 0;
  localparam int SRC_LSB = 1;
  localparam int PIN_CFG_W = 5;
  // Monitoring cycle: 8 per second
  localparam longint TICK_NS = 125000000;
  localparam longint CLK_NS = 10;
  localparam int TICK_W = 24;
  // Adjust delays in monitoring cycles, shifted by the cycle code
  localparam logic [11:0] DEC_BASE = 12'h008;
  localparam logic [11:0] INC_BASE = 12'h010;
  // Window of 0.25 s is 2 cycles; codes 5..7 saturate at 8 s
  localparam logic [6:0] WIN_BASE = 7'h02;
  localparam logic [2:0] WIN_CODE_MAX = 3'h4;
  localparam logic [6:0] WIN_LONG = 7'h40;

  typedef struct packed {
    logic [7:0] local_t;
    logic [7:0] rem1;
    logic [7:0] rem2;
    logic [7:0] rem3;
  } temps_t;
endpackage

/* File: design/thermal_pin_and_dynamic_floor_ctrl.sv */
// Thermal pin drive, external capture, assertion timers and floor pacing
`timescale 1ns/1ns
`default_nettype none

module thermal_pin_and_dynamic_floor_ctrl #(
  parameter int TICK_CYCLES = int'(thermal_pkg::TICK_NS / thermal_pkg::CLK_NS)
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid after reg_rd
  input wire logic lock, // Write-once lock level
  input wire logic sw_reset, // Software reset pulse
  input wire thermal_pkg::temps_t temps, // Current temperatures
  input wire thermal_pkg::temps_t limits_a, // Pin a limits
  input wire thermal_pkg::temps_t limits_b, // Pin b limits
  input wire logic [7:0] op_point_r1, // Remote one operating point
  input wire logic [7:0] op_point_r2, // Remote two operating point
  input wire logic thermal_pin_a_i, // Pin a level
  output logic thermal_pin_a_o, // Pin a drive value
  output logic thermal_pin_a_oe, // Pin a drive enable
  input wire logic thermal_pin_b_i, // Pin b level
  output logic thermal_pin_b_o, // Pin b drive value
  output logic thermal_pin_b_oe, // Pin b drive enable
  output logic fans_full_speed, // Force fans to full speed
  output logic cap_r1_stb, // Write operating point one
  output logic cap_r2_stb, // Write operating point two
  output logic [7:0] cap_r1_val, // Captured remote one temperature
  output logic [7:0] cap_r2_val, // Captured remote two temperature
  output logic [1:0] floor_dec_due, // Per remote decrease step due
  output logic [1:0] floor_inc_due, // Per remote increase step due
  output logic loop_newer, // Newer control loop selected
  output logic [6:0] pin_a_assert_ticks, // Asserted cycles, last window
  output logic [6:0] pin_b_assert_ticks // Asserted cycles, last window
);
  // Divider must fit the tick counter
  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << thermal_pkg::TICK_W)) begin
    $error("TICK_CYCLES out of range");
  end

  localparam logic [thermal_pkg::TICK_W-1:0] TICK_LAST =
    thermal_pkg::TICK_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [7:0] floor_a;
    logic [7:0] floor_b;
    logic [7:0] pin_common;
    logic [1:0][4:0] pin_cfg;
    logic [7:0] rdata;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [1:0] drive;
    logic [1:0] drive_d1;
    logic [1:0] drive_d2;
    logic [thermal_pkg::TICK_W-1:0] tick_cnt;
    logic [1:0][6:0] win_cnt;
    logic [1:0][6:0] asr_cnt;
    logic [1:0][6:0] asr_out;
    logic [1:0][11:0] adj_cnt;
    logic [1:0] dec_due;
    logic [1:0] inc_due;
    logic cap1;
    logic cap2;
    logic [7:0] cap1_val;
    logic [7:0] cap2_val;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [6:0] win_ticks(input logic [2:0] code);
    if (code > thermal_pkg::WIN_CODE_MAX) begin
      return thermal_pkg::WIN_LONG;
    end
    return thermal_pkg::WIN_BASE << code;
  endfunction

  function automatic logic [3:0] over(input thermal_pkg::temps_t t,
                                      input thermal_pkg::temps_t l);
    return {t.rem3 > l.rem3, t.rem2 > l.rem2, t.rem1 > l.rem1, t.local_t > l.local_t};
  endfunction

  logic tick;
  logic [1:0] ext_edge;
  logic [1:0][3:0] hot;
  logic [1:0][2:0] win_code;
  logic [1:0][2:0] cyc_code;

  always_comb begin
    s_d = s_q;
    tick = (s_q.tick_cnt == TICK_LAST);
    hot[0] = over(temps, limits_a);
    hot[1] = over(temps, limits_b);
    win_code[0] = s_q.pin_common[thermal_pkg::WIN_A_LSB +: 3];
    win_code[1] = s_q.pin_common[thermal_pkg::WIN_B_LSB +: 3];
    cyc_code[0] = s_q.floor_b[thermal_pkg::CYC_R1_LSB +: 3];
    cyc_code[1] = s_q.floor_b[thermal_pkg::CYC_R2_LSB +: 3];
    // Own drive is masked with the synchroniser's lag, so even a one-cycle
    // self-assertion never looks like an outside one
    ext_edge = s_q.prev & ~s_q.sync2 & ~s_q.drive_d2;
    s_d.drive_d1 = s_q.drive;
    s_d.drive_d2 = s_q.drive_d1;
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;
    s_d.sync1 = {thermal_pin_b_i, thermal_pin_a_i};
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    for (int p = 0; p < 2; p++) begin
      s_d.drive[p] = |(s_q.pin_cfg[p][thermal_pkg::SRC_LSB +: 4] & hot[p]);
      if (!s_q.pin_cfg[p][thermal_pkg::TIMER_EN]) begin
        s_d.win_cnt[p] = '0;
        s_d.asr_cnt[p] = '0;
      end else if (tick) begin
        if (s_q.win_cnt[p] + 7'h01 >= win_ticks(win_code[p])) begin
          s_d.asr_out[p] = s_q.asr_cnt[p] + {6'h00, ~s_q.sync2[p]};
          s_d.win_cnt[p] = '0;
          s_d.asr_cnt[p] = '0;
        end else begin
          s_d.win_cnt[p] = s_q.win_cnt[p] + 7'h01;
          s_d.asr_cnt[p] = s_q.asr_cnt[p] + {6'h00, ~s_q.sync2[p]};
        end
      end
      s_d.dec_due[p] = 1'b0;
      s_d.inc_due[p] = 1'b0;
      if (!s_q.floor_a[thermal_pkg::EN_R1 + p]) begin
        s_d.adj_cnt[p] = '0;
      end else if (tick) begin
        s_d.adj_cnt[p] = s_q.adj_cnt[p] + 12'h001;
        // Decrease falls due halfway through the increase interval
        s_d.dec_due[p] = (s_d.adj_cnt[p] == (thermal_pkg::DEC_BASE << cyc_code[p]));
        if (s_d.adj_cnt[p] == (thermal_pkg::INC_BASE << cyc_code[p])) begin
          s_d.inc_due[p] = 1'b1;
          s_d.adj_cnt[p] = '0;
        end
      end
    end
    s_d.cap1 = ((s_q.floor_a[thermal_pkg::CAP_A_R1] & ext_edge[0])
              | (s_q.floor_a[thermal_pkg::CAP_B_R1] & ext_edge[1]))
              & (temps.rem1 < op_point_r1);
    s_d.cap2 = ((s_q.floor_a[thermal_pkg::CAP_A_R2] & ext_edge[0])
              | (s_q.floor_a[thermal_pkg::CAP_B_R2] & ext_edge[1]))
              & (temps.rem2 < op_point_r2);
    if (s_d.cap1) begin
      s_d.cap1_val = temps.rem1;
    end
    if (s_d.cap2) begin
      s_d.cap2_val = temps.rem2;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        thermal_pkg::OFS_FLOOR_A: s_d.rdata = s_q.floor_a;
        thermal_pkg::OFS_FLOOR_B: s_d.rdata = s_q.floor_b;
        thermal_pkg::OFS_PIN_COMMON: s_d.rdata = s_q.pin_common;
        thermal_pkg::OFS_PIN_A: s_d.rdata = {3'h0, s_q.pin_cfg[0]};
        thermal_pkg::OFS_PIN_B: s_d.rdata = {3'h0, s_q.pin_cfg[1]};
        default: s_d.rdata = 8'h00;
      endcase
    end
    // A locked block keeps its settings through software reset too
    if (!lock) begin
      if (sw_reset) begin
        s_d.floor_a = thermal_pkg::RST_FLOOR_A;
        s_d.floor_b = thermal_pkg::RST_FLOOR_B;
        s_d.pin_common = thermal_pkg::RST_PIN_COMMON;
        s_d.pin_cfg = {thermal_pkg::RST_PIN_CFG, thermal_pkg::RST_PIN_CFG};
      end else if (reg_wr) begin
        unique case (reg_addr)
          thermal_pkg::OFS_FLOOR_A: s_d.floor_a = reg_wdata;
          thermal_pkg::OFS_FLOOR_B: s_d.floor_b = reg_wdata;
          thermal_pkg::OFS_PIN_COMMON: s_d.pin_common = reg_wdata;
          thermal_pkg::OFS_PIN_A: s_d.pin_cfg[0] = reg_wdata[thermal_pkg::PIN_CFG_W-1:0];
          thermal_pkg::OFS_PIN_B: s_d.pin_cfg[1] = reg_wdata[thermal_pkg::PIN_CFG_W-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.floor_b <= thermal_pkg::RST_FLOOR_B;
      s_q.sync1 <= 2'h3;
      s_q.sync2 <= 2'h3;
      s_q.prev <= 2'h3;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign thermal_pin_a_o = 1'b0;
  assign thermal_pin_b_o = 1'b0;
  assign thermal_pin_a_oe = s_q.drive[0];
  assign thermal_pin_b_oe = s_q.drive[1];
  assign fans_full_speed = (s_q.drive[0] & ~s_q.pin_common[thermal_pkg::BOOST_A])
                         | (s_q.drive[1] & ~s_q.pin_common[thermal_pkg::BOOST_B]);
  assign cap_r1_stb = s_q.cap1;
  assign cap_r2_stb = s_q.cap2;
  assign cap_r1_val = s_q.cap1_val;
  assign cap_r2_val = s_q.cap2_val;
  assign floor_dec_due = s_q.dec_due;
  assign floor_inc_due = s_q.inc_due;
  assign loop_newer = s_q.floor_b[thermal_pkg::LOOP_SEL];
  assign pin_a_assert_ticks = s_q.asr_out[0];
  assign pin_b_assert_ticks = s_q.asr_out[1];

  a_pin_a_drive: assert property (@(posedge clk_sys) disable iff (!resetn)
    |(s_q.pin_cfg[0][4:1] & over(temps, limits_a)) |=> thermal_pin_a_oe)
    else $error("pin a not driven while source over limit");
  a_pin_b_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(|(s_q.pin_cfg[1][4:1] & over(temps, limits_b))) |=> !thermal_pin_b_oe)
    else $error("pin b driven with no source over limit");
  a_boost_a_force: assert property (@(posedge clk_sys) disable iff (!resetn)
    thermal_pin_a_oe && !s_q.pin_common[thermal_pkg::BOOST_A] |-> fans_full_speed)
    else $error("fans not forced by pin a");
  a_cap_below_only: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(cap_r1_stb) |-> $past(temps.rem1) < $past(op_point_r1))
    else $error("capture with temperature not below point");
  a_cap_off_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    !s_q.floor_a[thermal_pkg::CAP_A_R2] && !s_q.floor_a[thermal_pkg::CAP_B_R2] |=> !cap_r2_stb)
    else $error("capture with capture bits clear");
  a_lock_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    lock && (reg_wr || sw_reset) |=> $stable(s_q.floor_a) && $stable(s_q.pin_common))
    else $error("locked register changed");
  a_swrst_value: assert property (@(posedge clk_sys) disable iff (!resetn)
    !lock && sw_reset |=> s_q.floor_b == thermal_pkg::RST_FLOOR_B && s_q.pin_cfg == '0)
    else $error("software reset did not restore defaults");
  a_dyn_off_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    !s_q.floor_a[thermal_pkg::EN_R1] ##1 !s_q.floor_a[thermal_pkg::EN_R1] |-> !floor_inc_due[0])
    else $error("adjust step while disabled");
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_rd && reg_addr == thermal_pkg::OFS_PIN_A |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
endmodule

`default_nettype wire

/* File: sim/pin_partner.sv */
// Outside party sharing both thermal pins; pins are pulled up when released
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input wire logic [1:0] ext_low, // Outside party pulls pin low
  input wire logic [1:0] dev_oe, // Device drive enables
  input wire logic [1:0] dev_o, // Device drive values
  output logic [1:0] level // Resolved pin levels
);
  // Open drain: any party pulling low wins, pull-up otherwise
  assign level = ~(ext_low | (dev_oe & ~dev_o));
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the thermal pin and dynamic floor block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((e) !== (g)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic lock = 1'b0, sw_reset = 1'b0, stb1, stb2, fans, newer;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, op1 = 8'hff, op2 = 8'hff;
  logic [7:0] rv, v1, v2;
  logic [7:0] rst [5] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
  thermal_pkg::temps_t temps = '0, lim_a = '1, lim_b = '1;
  logic [1:0] ext_low = 2'h0, oe, o, lvl, dec, inc;
  logic [6:0] ta, tb;
  int bad_count = 0, total_checks = 0, n1, n2, k;
  always #5 clk_sys = ~clk_sys;
  pin_partner far_u (.ext_low(ext_low), .dev_oe(oe), .dev_o(o), .level(lvl));
  // Short tick so pacing and windows fit in the run
  thermal_pin_and_dynamic_floor_ctrl #(.TICK_CYCLES(4)) dut_u (.clk_sys(clk_sys),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock(lock), .sw_reset(sw_reset),
    .temps(temps), .limits_a(lim_a), .limits_b(lim_b), .op_point_r1(op1),
    .op_point_r2(op2), .thermal_pin_a_i(lvl[0]), .thermal_pin_a_o(o[0]),
    .thermal_pin_a_oe(oe[0]), .thermal_pin_b_i(lvl[1]), .thermal_pin_b_o(o[1]),
    .thermal_pin_b_oe(oe[1]), .fans_full_speed(fans), .cap_r1_stb(stb1),
    .cap_r2_stb(stb2), .cap_r1_val(v1), .cap_r2_val(v2), .floor_dec_due(dec),
    .floor_inc_due(inc), .loop_newer(newer), .pin_a_assert_ticks(ta),
    .pin_b_assert_ticks(tb));
  task automatic give_verdict;
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    rv = reg_rdata;
  endtask
  task automatic swr;
    wr(8'h7b, 8'h6d);
    @(negedge clk_sys);
    sw_reset = 1'b1;
    @(negedge clk_sys);
    sw_reset = 1'b0;
  endtask
  task automatic chk_all;
    for (int i = 0; i < 5; i++) begin
      rd(8'h0b + 8'(i));
      `CHK("reset value", rst[i], rv)
    end
  endtask
  // Outside party holds a pin low for eight cycles; strobes are counted
  task automatic ext_try(input int p);
    n1 = 0;
    n2 = 0;
    @(negedge clk_sys);
    ext_low[p] = 1'b1;
    repeat (8) begin
      @(negedge clk_sys);
      n1 += int'(stb1 === 1'b1);
      n2 += int'(stb2 === 1'b1);
    end
    ext_low[p] = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // Cycles from a decrease pulse to the next increase pulse
  task automatic pace(input int r);
    k = 0;
    while (dec[r] !== 1'b1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (inc[r] !== 1'b1 && k < 3000);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    chk_all();
    `CHK("loop_reset", 1'b1, newer)
    rd(8'h20);
    `CHK("unmapped", 8'h00, rv)
    wr(8'h0e, 8'hff);
    rd(8'h0e);
    `CHK("pin_a_cfg", 8'h1f, rv)
    wr(8'h0b, 8'h3f);
    wr(8'h0c, 8'h3f);
    wr(8'h0d, 8'hff);
    wr(8'h0f, 8'hff);
    swr();
    chk_all();
    temps.rem1 = 8'h30;
    temps.rem2 = 8'h31;
    op1 = 8'h50;
    op2 = 8'h50;
    for (int b = 2; b < 6; b++) begin
      wr(8'h0b, 8'h01 << b);
      ext_try(b / 4);
      `CHK("cap_r1", int'(b % 2 == 0), n1)
      `CHK("cap_r2", int'(b % 2 == 1), n2)
    end
    `CHK("cap_val1", 8'h30, v1)
    `CHK("cap_val2", 8'h31, v2)
    wr(8'h0b, 8'h08);
    op2 = 8'h31;
    ext_try(0);
    `CHK("cap_r1_off", 0, n1)
    `CHK("cap_r2_equal", 0, n2)
    wr(8'h0b, 8'h00);
    wr(8'h0e, 8'h04);
    lim_a.rem1 = 8'h30;
    repeat (2) @(negedge clk_sys);
    `CHK("drive_equal", 1'b0, oe[0])
    lim_a.rem1 = 8'h2f;
    repeat (2) @(negedge clk_sys);
    `CHK("drive_a", 1'b1, oe[0])
    `CHK("fans_a", 1'b1, fans)
    wr(8'h0d, 8'h01);
    `CHK("fans_boost_a", 1'b0, fans)
    wr(8'h0f, 8'h02);
    temps.local_t = 8'h01;
    lim_b.local_t = 8'h00;
    repeat (2) @(negedge clk_sys);
    `CHK("drive_b", 1'b1, oe[1])
    `CHK("fans_b", 1'b1, fans)
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h00);
    repeat (2) @(negedge clk_sys);
    `CHK("drive_off", 2'h0, oe)
    `CHK("timer_off", 7'h00, ta)
    wr(8'h0e, 8'h01);
    wr(8'h0d, 8'h00);
    ext_low[0] = 1'b1;
    repeat (40) @(negedge clk_sys);
    `CHK("window_a", 7'h02, ta)
    wr(8'h0f, 8'h01);
    wr(8'h0d, 8'hb4);
    ext_low = 2'h3;
    repeat (600) @(negedge clk_sys);
    `CHK("window_a_long", 7'h40, ta)
    `CHK("window_b_long", 7'h40, tb)
    ext_low = 2'h0;
    wr(8'h0c, 8'h08);
    `CHK("loop_sel", 1'b0, newer)
    wr(8'h0b, 8'h03);
    pace(0);
    `CHK("pace_r1", 32, k)
    pace(1);
    `CHK("pace_r2", 64, k)
    wr(8'h0b, 8'h01);
    n1 = 0;
    repeat (300) begin
      @(negedge clk_sys);
      n1 += int'(inc[1] === 1'b1);
    end
    `CHK("r2_disabled", 0, n1)
    lock = 1'b1;
    wr(8'h0b, 8'h3c);
    swr();
    rd(8'h0b);
    `CHK("locked", 8'h01, rv)
    give_verdict();
  end
endmodule
`default_nettype wire
